// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the mmd indirect access slice over axi4-lite
// Assumes: mmd read data is handed in by the bench, held across each read
// Notes:   random values from a fixed seed, with boundary devices and an address wrap
`timescale 1ns/1ps
`default_nettype none
`include "mia_map.svh"

module tb_top
    import mia_pkg::*;
;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [15:0] mrdata;
    wire logic        awready, wready, bvalid, arready, rvalid, mwr, mrd;
    wire logic [1:0]  bresp, rresp, mbe;
    wire logic [31:0] rdata;
    wire logic [4:0]  mdev;
    wire logic [15:0] maddr, mwdata;
    int          err_total, n_checks;
    int          wr_cnt = 0;
    int          rd_cnt = 0;
    logic [15:0] wr_addr, rd_addr, wr_dat;
    logic [1:0]  wr_be;

    mia_regs DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mmd_dev_o(mdev), .mmd_addr_o(maddr),
        .mmd_wdata_o(mwdata), .mmd_be_o(mbe), .mmd_wr_o(mwr), .mmd_rd_o(mrd),
        .mmd_rdata_i(mrdata));

    always #2.5 clk = ~clk;

    // ----------------------------------------------------------------
    // mmd port monitor
    // ----------------------------------------------------------------
    // sampled before the edge lands, so the pulse cycle values are kept
    always @(posedge clk) begin
        if (mwr === 1'b1) begin
            wr_cnt  <= wr_cnt + 1;
            wr_addr <= maddr;
            wr_dat  <= mwdata;
            wr_be   <= mbe;
        end
        if (mrd === 1'b1) begin
            rd_cnt  <= rd_cnt + 1;
            rd_addr <= maddr;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hang(input string nm);
        err_total++;
        $display("CHECK FAILED %s expected answer seen none", nm);
        final_report;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    function automatic logic [15:0] next_addr(input logic [1:0] op, input logic [15:0] a,
                                              input logic wr);
        if (op == 2'b10 || (op == 2'b11 && wr))
            return a + 16'h0001;
        return a;
    endfunction

    // starts one edge late so a release by the previous call has landed
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bready && bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n >= 100) hang("axi write");
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rready && rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n >= 100) hang("axi read");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r, op;
        logic [4:0]  dev;
        logic [15:0] a, w, rv;
        logic [8:0]  rsv;
        logic [15:0] exp_addr [32];
        int          k, c0, c1;
        clk = 0; rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; mrdata = 0;
        err_total = 0; n_checks = 0;
        for (k = 0; k < 32; k++) exp_addr[k] = 16'h0000;
        void'($urandom(94));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(`MIA_ADDR_CTRL, d, r);
        chk_val("control reset", 32'h0000_0000, d);
        axi_rd(`MIA_ADDR_WIN, d, r);
        chk_val("window reset", 32'h0000_0000, d);
        // a write to the read-only status must not stick
        axi_wr(`MIA_ADDR_STAT, 32'h0000_ffff, 4'hf, r);
        axi_rd(`MIA_ADDR_STAT, d, r);
        chk_val("extended status", 32'h0000_3000, d);
        axi_rd(8'h00, d, r);
        chk_resp("unmapped read", 2'b10, r);
        axi_wr(8'h00, 32'h0000_1234, 4'hf, r);
        chk_resp("unmapped write", 2'b10, r);
        for (k = 1; k < 4; k++) begin
            op  = k[1:0];
            dev = (k == 1) ? 5'h00 : (k == 2) ? 5'h1f : 5'($urandom_range(1, 30));
            a   = (k == 2) ? 16'hfffe : 16'($urandom);
            w   = 16'($urandom);
            rsv = 9'($urandom);
            axi_wr(`MIA_ADDR_CTRL, {16'h0000, MIA_OP_REG, 9'h000, dev}, 4'h3, r);
            c0 = wr_cnt;
            c1 = rd_cnt;
            axi_wr(`MIA_ADDR_WIN, {16'h0000, a}, 4'h3, r);
            chk_val("address mode data writes", 32'(c0), 32'(wr_cnt));
            axi_rd(`MIA_ADDR_WIN, d, r);
            chk_val("stored address", {16'h0000, a}, d);
            chk_val("address mode data reads", 32'(c1), 32'(rd_cnt));
            chk_val("device select", {27'h0, dev}, {27'h0, mdev});
            axi_wr(`MIA_ADDR_CTRL, {16'h0000, op, rsv, dev}, 4'h3, r);
            axi_rd(`MIA_ADDR_CTRL, d, r);
            chk_val("control readback", {16'h0000, op, rsv, dev}, d);
            axi_wr(`MIA_ADDR_WIN, {16'h0000, w}, (k == 3) ? 4'h1 : 4'h3, r);
            chk_val("data write address", {16'h0000, a}, {16'h0000, wr_addr});
            chk_val("data write value", {16'h0000, w}, {16'h0000, wr_dat});
            chk_val("data strobes", {30'h0, (k == 3) ? 2'b01 : 2'b11}, {30'h0, wr_be});
            chk_val("data write pulses", 32'(c0 + 1), 32'(wr_cnt));
            chk_resp("window write response", 2'b00, r);
            a = next_addr(op, a, 1'b1);
            repeat (2) begin
                rv = 16'($urandom);
                mrdata <= rv;
                c1 = rd_cnt;
                axi_rd(`MIA_ADDR_WIN, d, r);
                chk_val("data read value", {16'h0000, rv}, d);
                chk_val("data read pulses", 32'(c1 + 1), 32'(rd_cnt));
                chk_resp("window read response", 2'b00, r);
                chk_val("read address", {16'h0000, a}, {16'h0000, rd_addr});
                a = next_addr(op, a, 1'b0);
            end
            exp_addr[dev] = a;
            axi_wr(`MIA_ADDR_CTRL, {16'h0000, MIA_OP_REG, 9'h000, dev}, 4'h3, r);
            axi_rd(`MIA_ADDR_WIN, d, r);
            chk_val("address after data", {16'h0000, a}, d);
            axi_wr(`MIA_ADDR_CTRL, {16'h0000, MIA_OP_REG, 9'h000, dev ^ 5'h01}, 4'h3, r);
            axi_rd(`MIA_ADDR_WIN, d, r);
            chk_val("other device address", {16'h0000, exp_addr[dev ^ 5'h01]}, d);
        end
        final_report;
    end
endmodule // tb_top

`default_nettype wire

// ==== rtl/mia_map.svh ====
// Purpose: offsets, fields, reset values and codes of the mmd access slice
// Assumes: registers sit at byte address four times their index
// Notes:   definitions only
`ifndef MIA_MAP_SVH
`define MIA_MAP_SVH

`define MIA_IDX_CTRL   6'h0d
`define MIA_IDX_WIN    6'h0e
`define MIA_IDX_STAT   6'h0f
`define MIA_ADDR_CTRL  ({`MIA_IDX_CTRL, 2'b00})
`define MIA_ADDR_WIN   ({`MIA_IDX_WIN, 2'b00})
`define MIA_ADDR_STAT  ({`MIA_IDX_STAT, 2'b00})

`define MIA_OP_HI      15
`define MIA_OP_LO      14
`define MIA_DEV_HI     4
`define MIA_NUM_DEV    32

`define MIA_CTRL_RST   16'h0000
`define MIA_WIN_RST    16'h0000
`define MIA_STAT_VAL   16'h3000

`define MIA_RESP_OKAY  2'b00
`define MIA_RESP_SLV   2'b10

`endif

// ==== rtl/mia_pkg.sv ====
// Purpose: types of the mmd access slice
// Assumes: none
// Notes:   numbers live in mia_map.svh
package mia_pkg;

    typedef enum logic [1:0] {
        MIA_OP_REG    = 2'b00,
        MIA_OP_DATA   = 2'b01,
        MIA_OP_INC_RW = 2'b10,
        MIA_OP_INC_W  = 2'b11
    } mia_op_t;

    typedef enum logic [1:0] {
        MIA_SEL_NONE,
        MIA_SEL_CTRL,
        MIA_SEL_WIN,
        MIA_SEL_STAT
    } mia_sel_t;

endpackage

// ==== rtl/mia_regs.sv ====
// Purpose: mmd indirect access control, window and extended status over axi4-lite
// Assumes: mmd register contents sit outside, answering on the mmd port
// Notes:   one write and one read in flight at a time
//
// Overview of operation
// - operation field at control bits 15:14; 00 makes window the address holder.
// - operation 01 moves data and leaves the stored address unchanged.
// - operation 10 moves data and advances the address after reads and writes.
// - operation 11 moves data and advances the address after writes only.
// - control bits 4:0 hold the device address, reset zero, used by window.
// - with operation 00 window writes load and reads return the stored address.
// - with nonzero operation window accesses reach the addressed mmd register data.
// - extended status bits 15 and 14 read zero, read only.
// - extended status bits 13 and 12 read one, read only.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mia_map.svh"

module mia_regs
    import mia_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [4:0]       mmd_dev_o,
    output logic [15:0]      mmd_addr_o,
    output logic [15:0]      mmd_wdata_o,
    output logic [1:0]       mmd_be_o,
    output logic             mmd_wr_o,
    output logic             mmd_rd_o,
    input  wire logic [15:0] mmd_rdata_i
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic mia_sel_t decode(input logic [7:0] a);
        case (a)
            `MIA_ADDR_CTRL: decode = MIA_SEL_CTRL;
            `MIA_ADDR_WIN:  decode = MIA_SEL_WIN;
            `MIA_ADDR_STAT: decode = MIA_SEL_STAT;
            default:        decode = MIA_SEL_NONE;
        endcase
    endfunction

    function automatic logic [15:0] merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  be
    );
        merge = {be[1] ? new_v[15:8] : old_v[15:8],
                 be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic        aw_full_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_full_reg;
    logic [15:0] w_data_reg;
    logic [1:0]  w_be_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [15:0] rdata_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] addr_mem [`MIA_NUM_DEV];

    logic        wr_go;
    logic        rd_go;
    mia_sel_t    wr_sel;
    mia_sel_t    rd_sel;
    mia_op_t     op;
    logic [4:0]  dev;
    logic [15:0] cur_addr;
    logic        ctrl_wr;
    logic        win_wr;
    logic        win_rd;
    logic        inc_w;
    logic        inc_r;
    logic [15:0] step;
    logic [15:0] rd_word;

    // ------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------
    // address and data are held apart so either may arrive first
    assign s_axi_awready_o = !aw_full_reg;
    assign s_axi_wready_o  = !w_full_reg;
    assign wr_go  = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_sel = decode(aw_addr_reg);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid_i && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end else if (wr_go) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_be_reg   <= 2'b00;
        end else if (s_axi_wvalid_i && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i[15:0];
            w_be_reg   <= s_axi_wstrb_i[1:0];
        end else if (wr_go) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `MIA_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel == MIA_SEL_NONE) ? `MIA_RESP_SLV : `MIA_RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o  = bresp_reg;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    assign ctrl_wr = wr_go && (wr_sel == MIA_SEL_CTRL);
    assign op      = mia_op_t'(ctrl_reg[`MIA_OP_HI:`MIA_OP_LO]);
    assign dev     = ctrl_reg[`MIA_DEV_HI:0];

    // reserved bits 13:5 are kept as plain storage
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= `MIA_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_be_reg);
        end
    end

    // ------------------------------------------------------------
    // window and stored addresses
    // ------------------------------------------------------------
    // one stored address per device, so switching devices loses nothing
    assign cur_addr = addr_mem[dev];
    assign win_wr   = wr_go && (wr_sel == MIA_SEL_WIN);
    assign win_rd   = rd_go && (rd_sel == MIA_SEL_WIN);
    assign inc_w    = win_wr &&
                      ((op == MIA_OP_INC_RW) || (op == MIA_OP_INC_W));
    assign inc_r    = win_rd && (op == MIA_OP_INC_RW);
    // a read and a write in one cycle each count
    assign step     = {15'h0000, inc_w} + {15'h0000, inc_r};

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `MIA_NUM_DEV; i++) begin
                addr_mem[i] <= `MIA_WIN_RST;
            end
        end else if (win_wr && (op == MIA_OP_REG)) begin
            addr_mem[dev] <= merge(cur_addr, w_data_reg, w_be_reg);
        end else if (inc_w || inc_r) begin
            addr_mem[dev] <= cur_addr + step;
        end
    end

    // ------------------------------------------------------------
    // mmd data port
    // ------------------------------------------------------------
    assign mmd_dev_o   = dev;
    assign mmd_addr_o  = cur_addr;
    assign mmd_wdata_o = w_data_reg;
    assign mmd_be_o    = w_be_reg;
    assign mmd_wr_o    = win_wr && (op != MIA_OP_REG);
    assign mmd_rd_o    = win_rd && (op != MIA_OP_REG);

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready_o = !rvalid_reg;
    assign rd_go  = s_axi_arvalid_i && !rvalid_reg;
    assign rd_sel = decode(s_axi_araddr_i);

    always_comb begin
        case (rd_sel)
            MIA_SEL_CTRL: rd_word = ctrl_reg;
            MIA_SEL_WIN:  rd_word = (op == MIA_OP_REG) ? cur_addr
                                                       : mmd_rdata_i;
            MIA_SEL_STAT: rd_word = `MIA_STAT_VAL;
            default:      rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `MIA_RESP_OKAY;
            rdata_reg  <= 16'h0000;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (rd_sel == MIA_SEL_NONE) ? `MIA_RESP_SLV : `MIA_RESP_OKAY;
            rdata_reg  <= rd_word;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o  = rresp_reg;
    assign s_axi_rdata_o  = {16'h0000, rdata_reg};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_wr_taken;
        wr_go;
    endsequence

    sequence s_wr_answered;
        s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
    endsequence

    a_write_resp: assert property (s_wr_taken |=> s_wr_answered)
        else $error("write response missing after write");

    a_reg_no_mmd: assert property (
        (win_rd || win_wr) && (op == MIA_OP_REG) |-> !mmd_rd_o && !mmd_wr_o)
        else $error("mmd strobe in register mode");

    a_data_hold: assert property (
        (win_rd || win_wr) && (op == MIA_OP_DATA) && !ctrl_wr
        |=> cur_addr == $past(cur_addr))
        else $error("address moved without post increment");

    a_incr_read: assert property (
        win_rd && !win_wr && (op == MIA_OP_INC_RW) && !ctrl_wr
        |=> cur_addr == $past(cur_addr) + 16'h0001)
        else $error("no increment after read");

    a_incr_write: assert property (
        win_wr && !win_rd && ((op == MIA_OP_INC_W) || (op == MIA_OP_INC_RW))
        |=> cur_addr == $past(cur_addr) + 16'h0001)
        else $error("no increment after write");

    a_read_hold: assert property (
        win_rd && !win_wr && (op == MIA_OP_INC_W) && !ctrl_wr
        |=> $stable(cur_addr))
        else $error("read advanced address in write only mode");

    a_dev_write: assert property (
        ctrl_wr && w_be_reg[0] |=> mmd_dev_o == $past(w_data_reg[4:0]))
        else $error("device address not taken");

    a_addr_load: assert property (
        win_wr && (op == MIA_OP_REG) && (w_be_reg == 2'b11)
        |=> cur_addr == $past(w_data_reg))
        else $error("window write did not load address");

    a_addr_read: assert property (
        win_rd && (op == MIA_OP_REG) |=> s_axi_rdata_o[15:0] == $past(cur_addr))
        else $error("window read did not return address");

    a_data_route: assert property (
        win_rd && (op != MIA_OP_REG)
        |-> mmd_rd_o ##1 s_axi_rvalid_o && s_axi_rdata_o[15:0] == $past(mmd_rdata_i))
        else $error("mmd data not returned");

    a_stat_x: assert property (
        rd_go && (rd_sel == MIA_SEL_STAT) |=> s_axi_rdata_o[15:14] == 2'b00)
        else $error("1000base-x capability shown");

    a_stat_t: assert property (
        rd_go && (rd_sel == MIA_SEL_STAT) |=> s_axi_rdata_o[13:12] == 2'b11)
        else $error("1000base-t capability missing");

    a_step_one: assert property (
        (inc_w ^ inc_r) && !ctrl_wr |=> (cur_addr - $past(cur_addr)) == 16'h0001)
        else $error("increment step not one");

endmodule // mia_regs

`default_nettype wire
